// ### hw/plc_cfg.svh
// Register offsets, field positions, reset values and timing constants of the modem register bank.
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH

`define ADDR_TX_LEN 8'h06
`define ADDR_TX_CFG 8'h07
`define ADDR_DA_FIRST 8'h08
`define ADDR_DA_LAST 8'h0F
`define ADDR_NOISE 8'h30
`define ADDR_MODEM 8'h31
`define ADDR_TX_GAIN 8'h32
`define ADDR_RX_GAIN 8'h33
`define ADDR_RX_INFO 8'h40

`define TXLEN_SEND_BIT 7
`define TXLEN_LEN_HI 4
`define TXCFG_SA_BIT 7
`define TXCFG_DA_HI 6
`define TXCFG_DA_LO 5
`define TXCFG_SVC_BIT 4
`define TXCFG_RETRY_HI 3
`define NOISE_AUTO_BIT 3
`define NOISE_CODE_HI 2
`define MODEM_DELAY_HI 6
`define MODEM_DELAY_LO 5
`define MODEM_TONE_BIT 4
`define MODEM_RATE_HI 1
`define RXINFO_NEW_BIT 7

`define MASK_TX_LEN 8'h9F
`define MASK_TX_CFG 8'hFF
`define MASK_NOISE 8'h0F
`define MASK_MODEM 8'h73
`define MASK_TX_GAIN 8'h0F
`define MASK_RX_GAIN 8'h07

`define RST_TX_LEN 8'h00
`define RST_TX_CFG 8'h00
`define RST_NOISE 8'h03
`define RST_MODEM 8'h03
`define RST_TX_GAIN 8'h0B
`define RST_RX_GAIN 8'h00
`define TX_GAIN_RESERVED 4'hF

`define ZERO_TONE_100HZ 16'h0535
`define ONE_TONE_NARROW_100HZ 16'h0526
`define ONE_TONE_WIDE_100HZ 16'h0518

`define CLK_KHZ 25000
`define ACK_WINDOW_MS 500
`define ACK_WINDOW_CYCLES (`ACK_WINDOW_MS * `CLK_KHZ)

`endif

// ### hw/plc_pkg.sv
// Types shared by the modem register bank and its acknowledgement timer.
`default_nettype none
package plc_pkg;

  typedef enum logic [1:0] {
    DA_LOGICAL = 2'b00,
    DA_GROUP = 2'b01,
    DA_PHYSICAL = 2'b10,
    DA_INVALID = 2'b11
  } dest_addr_kind_t;

  typedef enum logic [0:0] {
    ACK_IDLE = 1'b0,
    ACK_WAIT = 1'b1
  } ack_state_t;

  typedef struct packed {
    logic send;
    logic [4:0] payload_len;
    logic source_addr_kind;
    dest_addr_kind_t dest_addr_kind;
    logic ack_mode;
    logic [3:0] retry_count;
  } tx_ctrl_t;

  typedef struct packed {
    logic [63:0] physical;
    logic [15:0] logical16;
    logic [7:0] logical8;
  } dest_addr_t;

  typedef struct packed {
    logic [1:0] tx_delay;
    logic tone_deviation_select;
    logic [15:0] zero_tone_100hz;
    logic [15:0] one_tone_100hz;
    logic [1:0] bit_rate;
    logic [11:0] rate_bps;
    logic [3:0] tx_gain;
    logic [2:0] rx_gain;
  } modem_t;

  typedef struct packed {
    logic auto_noise_threshold;
    logic [2:0] noise_threshold_code;
    logic [2:0] band_in_use_code;
    logic [6:0] band_in_use_dbuv;
  } noise_t;

endpackage : plc_pkg
`default_nettype wire

// ### hw/ack_timer.sv
// Acknowledgement window timer: counts down after a send and flags a missing answer.
`timescale 1ns/1ps
`default_nettype none
module ack_timer #(
  parameter int CNT_W = 24
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic stop,
  input wire logic [CNT_W-1:0] limit,
  output logic running,
  output logic expired
);

  plc_pkg::ack_state_t state;
  plc_pkg::ack_state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_expired;

  always_comb begin
    next_state = state;
    next_count = count;
    next_expired = 1'b0;
    case (state)
      plc_pkg::ACK_IDLE: begin
        if (start) begin
          next_state = plc_pkg::ACK_WAIT;
          next_count = limit;
        end
      end
      plc_pkg::ACK_WAIT: begin
        if (stop) begin
          next_state = plc_pkg::ACK_IDLE;
        end else if (count <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          next_state = plc_pkg::ACK_IDLE;
          next_expired = 1'b1;
        end else begin
          next_count = count - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      default: next_state = plc_pkg::ACK_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= plc_pkg::ACK_IDLE;
      count <= '0;
      expired <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      expired <= next_expired;
    end
  end

  assign running = (state == plc_pkg::ACK_WAIT);

  a_timer_expiry: assert property (@(posedge clk) disable iff (sys_rst)
    running && !stop && count == {{(CNT_W-1){1'b0}}, 1'b1} |=> expired && !running)
    else $error("ack timer did not expire at end of window");

endmodule : ack_timer
`default_nettype wire

// ### hw/plc_config_regs.sv
// Host-visible configuration register bank of the powerline modem node.
`timescale 1ns/1ps
`default_nettype none
`include "plc_cfg.svh"
module plc_config_regs #(
  parameter int ACK_CYCLES = `ACK_WINDOW_CYCLES,
  parameter int CNT_W = 24
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic rx_packet,
  input wire logic tx_done,
  input wire logic ack_rcvd,
  input wire logic [2:0] auto_noise_code,
  output logic rx_accept,
  output logic rx_dropped,
  output logic int_status_clear,
  output logic ack_missing,
  output logic ack_pending,
  output plc_pkg::tx_ctrl_t tx_ctrl,
  output plc_pkg::dest_addr_t dest_addr,
  output plc_pkg::modem_t modem,
  output plc_pkg::noise_t noise
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage and write decode.

  logic [7:0] tx_len;
  logic [7:0] tx_cfg;
  logic [7:0] noise_reg;
  logic [7:0] modem_reg;
  logic [7:0] tx_gain;
  logic [7:0] rx_gain;
  logic [7:0] da_byte [8];
  logic new_msg;

  wire wr_tx_len = reg_wr && reg_addr == `ADDR_TX_LEN;
  wire wr_tx_cfg = reg_wr && reg_addr == `ADDR_TX_CFG;
  wire wr_da = reg_wr && reg_addr >= `ADDR_DA_FIRST && reg_addr <= `ADDR_DA_LAST;
  wire [2:0] da_index = reg_addr[2:0];
  wire wr_noise = reg_wr && reg_addr == `ADDR_NOISE;
  wire wr_modem = reg_wr && reg_addr == `ADDR_MODEM;
  // A reserved gain code is dropped so the amplifier never sees it.
  wire gain_reserved = reg_wdata[3:0] == `TX_GAIN_RESERVED;
  wire wr_tx_gain = reg_wr && reg_addr == `ADDR_TX_GAIN && !gain_reserved;
  wire wr_rx_gain = reg_wr && reg_addr == `ADDR_RX_GAIN;
  // Only a zero may be written to the flag; writing one is ignored.
  wire clear_msg = reg_wr && reg_addr == `ADDR_RX_INFO && !reg_wdata[`RXINFO_NEW_BIT];

  // A packet arriving in the cycle of the clear is still taken.
  wire next_accept = rx_packet && (!new_msg || clear_msg);
  wire next_new_msg = next_accept || (new_msg && !clear_msg);
  // The host write wins so a send issued as the previous one ends is kept.
  wire next_send = wr_tx_len ? reg_wdata[`TXLEN_SEND_BIT] :
                   (tx_done ? 1'b0 : tx_len[`TXLEN_SEND_BIT]);
  wire [7:0] len_masked = reg_wdata & `MASK_TX_LEN;
  wire [6:0] next_len = wr_tx_len ? len_masked[6:0] : tx_len[6:0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_len <= `RST_TX_LEN;
      tx_cfg <= `RST_TX_CFG;
      noise_reg <= `RST_NOISE;
      modem_reg <= `RST_MODEM;
      tx_gain <= `RST_TX_GAIN;
      rx_gain <= `RST_RX_GAIN;
      new_msg <= 1'b0;
    end else begin
      tx_len <= {next_send, next_len};
      if (wr_tx_cfg) tx_cfg <= reg_wdata & `MASK_TX_CFG;
      if (wr_noise) noise_reg <= reg_wdata & `MASK_NOISE;
      if (wr_modem) modem_reg <= reg_wdata & `MASK_MODEM;
      if (wr_tx_gain) tx_gain <= reg_wdata & `MASK_TX_GAIN;
      if (wr_rx_gain) rx_gain <= reg_wdata & `MASK_RX_GAIN;
      new_msg <= next_new_msg;
    end
  end

  // Address bytes have no reset: the host must program them before a send.
  always_ff @(posedge clk) begin
    if (wr_da) da_byte[da_index] <= reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event pulses and read port.

  wire [7:0] rx_info = {new_msg, 7'h00};
  wire [7:0] read_mux =
    reg_addr == `ADDR_TX_LEN ? tx_len :
    reg_addr == `ADDR_TX_CFG ? tx_cfg :
    (reg_addr >= `ADDR_DA_FIRST && reg_addr <= `ADDR_DA_LAST) ? da_byte[da_index] :
    reg_addr == `ADDR_NOISE ? noise_reg :
    reg_addr == `ADDR_MODEM ? modem_reg :
    reg_addr == `ADDR_TX_GAIN ? tx_gain :
    reg_addr == `ADDR_RX_GAIN ? rx_gain :
    reg_addr == `ADDR_RX_INFO ? rx_info : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      rx_accept <= 1'b0;
      rx_dropped <= 1'b0;
      int_status_clear <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? read_mux : reg_rdata;
      reg_rvalid <= reg_rd;
      rx_accept <= next_accept;
      rx_dropped <= rx_packet && !next_accept;
      int_status_clear <= clear_msg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded configuration towards the modem and protocol engine.

  localparam logic [6:0] DBUV [8] = '{7'h46, 7'h4B, 7'h50, 7'h57, 7'h5A, 7'h5D, 7'h60, 7'h63};
  localparam logic [11:0] BPS [4] = '{12'h258, 12'h4B0, 12'h708, 12'h960};

  wire auto_thr = noise_reg[`NOISE_AUTO_BIT];
  wire [2:0] thr_code = noise_reg[`NOISE_CODE_HI:0];
  wire [2:0] eff_code = auto_thr ? auto_noise_code : thr_code;
  wire [1:0] rate = modem_reg[`MODEM_RATE_HI:0];
  wire tone_sel = modem_reg[`MODEM_TONE_BIT];

  assign tx_ctrl.send = tx_len[`TXLEN_SEND_BIT];
  assign tx_ctrl.payload_len = tx_len[`TXLEN_LEN_HI:0];
  assign tx_ctrl.source_addr_kind = tx_cfg[`TXCFG_SA_BIT];
  assign tx_ctrl.dest_addr_kind = plc_pkg::dest_addr_kind_t'(tx_cfg[`TXCFG_DA_HI:`TXCFG_DA_LO]);
  assign tx_ctrl.ack_mode = tx_cfg[`TXCFG_SVC_BIT];
  assign tx_ctrl.retry_count = tx_cfg[`TXCFG_RETRY_HI:0];

  assign dest_addr.physical = {da_byte[0], da_byte[1], da_byte[2], da_byte[3],
                               da_byte[4], da_byte[5], da_byte[6], da_byte[7]};
  assign dest_addr.logical16 = {da_byte[1], da_byte[0]};
  assign dest_addr.logical8 = da_byte[0];

  assign modem.tx_delay = modem_reg[`MODEM_DELAY_HI:`MODEM_DELAY_LO];
  assign modem.tone_deviation_select = tone_sel;
  assign modem.zero_tone_100hz = `ZERO_TONE_100HZ;
  assign modem.one_tone_100hz = tone_sel ? `ONE_TONE_WIDE_100HZ : `ONE_TONE_NARROW_100HZ;
  assign modem.bit_rate = rate;
  assign modem.rate_bps = BPS[rate];
  assign modem.tx_gain = tx_gain[3:0];
  assign modem.rx_gain = rx_gain[2:0];

  assign noise.auto_noise_threshold = auto_thr;
  assign noise.noise_threshold_code = thr_code;
  assign noise.band_in_use_code = eff_code;
  assign noise.band_in_use_dbuv = DBUV[eff_code];

  ////////////////////////////////////////////////////////////////////////////////
  // Acknowledgement window, armed only by an acknowledged send.

  wire ack_start = tx_done && tx_cfg[`TXCFG_SVC_BIT];

  ack_timer #(
    .CNT_W(CNT_W)
  ) u_ack_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(ack_start),
    .stop(ack_rcvd),
    .limit(CNT_W'(ACK_CYCLES)),
    .running(ack_pending),
    .expired(ack_missing)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_gain_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == `ADDR_TX_GAIN && reg_wdata[3:0] == 4'hF |=> $stable(modem.tx_gain))
    else $error("reserved transmit gain code was stored");
  a_reset_values: assert property (@(posedge clk)
    $past(sys_rst) |-> thr_code == 3'h3 && rate == 2'h3 && tx_gain[3:0] == 4'hB
      && rx_gain[2:0] == 3'h0)
    else $error("wrong value after reset");
  a_send_clear: assert property (@(posedge clk) disable iff (sys_rst)
    tx_done && !wr_tx_len |=> !tx_ctrl.send)
    else $error("send bit not cleared after transmission");
  a_msg_hold: assert property (@(posedge clk) disable iff (sys_rst)
    new_msg && rx_packet && !clear_msg |=> rx_dropped && !rx_accept && new_msg)
    else $error("second message taken while flag still set");
  a_msg_set: assert property (@(posedge clk) disable iff (sys_rst)
    rx_packet && !new_msg |=> rx_accept && new_msg)
    else $error("received packet did not set the flag");
  a_status_clear: assert property (@(posedge clk) disable iff (sys_rst)
    clear_msg |=> int_status_clear ##1 !int_status_clear || $past(clear_msg))
    else $error("status clear pulse missing");
  a_auto_thr: assert property (@(posedge clk) disable iff (sys_rst)
    auto_thr |-> noise.band_in_use_code == auto_noise_code)
    else $error("programmed threshold used in automatic mode");
  a_retry_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_tx_cfg |=> tx_ctrl.retry_count == $past(reg_wdata[3:0])
      && tx_ctrl.ack_mode == $past(reg_wdata[4]))
    else $error("transmit configuration not stored");
  a_addr_order: assert property (@(posedge clk) disable iff (sys_rst)
    wr_da && reg_addr == 8'h08 |=> dest_addr.physical[63:56] == $past(reg_wdata)
      && dest_addr.logical16[7:0] == $past(reg_wdata))
    else $error("address byte order wrong");
  a_tone_pair: assert property (@(posedge clk) disable iff (sys_rst)
    modem.one_tone_100hz == (tone_sel ? 16'h0518 : 16'h0526))
    else $error("logic one tone wrong");
  a_ack_only_acked: assert property (@(posedge clk) disable iff (sys_rst)
    tx_done && !tx_ctrl.ack_mode && !ack_pending |=> !ack_pending)
    else $error("ack window opened in unacknowledged mode");

  c_acked_send: cover property (@(posedge clk) disable iff (sys_rst) ack_start);
  c_msg_dropped: cover property (@(posedge clk) disable iff (sys_rst) rx_dropped);
  c_clear_and_take: cover property (@(posedge clk) disable iff (sys_rst) clear_msg && rx_packet);
  c_ack_missing: cover property (@(posedge clk) disable iff (sys_rst) ack_missing);

endmodule : plc_config_regs
`default_nettype wire

// ### test/plc_host_model.sv
// Host microcontroller model issuing byte writes and reads on the register port.
`timescale 1ns/1ps
`default_nettype none
module plc_host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Released lines show the inverse so that a stale value never looks live.
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk);
    ok = reg_rvalid;
    d = reg_rdata;
  endtask : rd
endmodule : plc_host_model
`default_nettype wire

// ### test/tb_powerline_modem_config_regs.sv
// Self-checking testbench of the modem configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_powerline_modem_config_regs;
  localparam int ACK = 20;
  logic clk, sys_rst, rx_packet, tx_done, ack_rcvd;
  logic [2:0] auto_noise_code;
  logic reg_wr, reg_rd, reg_rvalid, rx_accept, rx_dropped, int_status_clear;
  logic ack_missing, ack_pending, ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r;
  plc_pkg::tx_ctrl_t tx_ctrl;
  plc_pkg::dest_addr_t dest_addr;
  plc_pkg::modem_t modem;
  plc_pkg::noise_t noise;
  logic [31:0] seed, v, w;
  logic [63:0] phys;
  logic [3:0] g;
  logic [2:0] c;
  int n_mismatch, num_checks, k, miss;
  logic [7:0] ra [7] = '{8'h07, 8'h30, 8'h31, 8'h32, 8'h33, 8'h40, 8'h20};
  logic [7:0] rv [7] = '{8'h00, 8'h03, 8'h03, 8'h0B, 8'h00, 8'h00, 8'h00};

  plc_config_regs #(.ACK_CYCLES(ACK)) DUT (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .rx_packet(rx_packet), .tx_done(tx_done), .ack_rcvd(ack_rcvd),
    .auto_noise_code(auto_noise_code), .rx_accept(rx_accept), .rx_dropped(rx_dropped),
    .int_status_clear(int_status_clear), .ack_missing(ack_missing),
    .ack_pending(ack_pending), .tx_ctrl(tx_ctrl), .dest_addr(dest_addr), .modem(modem),
    .noise(noise));
  plc_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [6:0] exp_dbuv(input logic [2:0] code);
    case (code)
      3'h0: return 7'h46;
      3'h1: return 7'h4B;
      3'h2: return 7'h50;
      3'h3: return 7'h57;
      3'h4: return 7'h5A;
      3'h5: return 7'h5D;
      3'h6: return 7'h60;
      default: return 7'h63;
    endcase
  endfunction : exp_dbuv
  function automatic logic [11:0] exp_bps(input logic [1:0] rate);
    case (rate)
      2'h0: return 12'h258;
      2'h1: return 12'h4B0;
      2'h2: return 12'h708;
      default: return 12'h960;
    endcase
  endfunction : exp_bps
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    host.wr(a, d);
    host.rd(a, r, ok);
    chk({ok, r}, {1'b1, e}, "readback");
  endtask : wr_rd
  // Pulses one event input for a single cycle, then waits until its answer has settled.
  task automatic pulse(input int which);
    @(posedge clk);
    rx_packet <= (which == 0);
    tx_done <= (which == 1);
    ack_rcvd <= (which == 2);
    @(posedge clk);
    rx_packet <= 1'b0;
    tx_done <= 1'b0;
    ack_rcvd <= 1'b0;
    @(negedge clk);
  endtask : pulse
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    seed = 32'h29D0;
    sys_rst = 1'b1;
    {rx_packet, tx_done, ack_rcvd, auto_noise_code} = 6'h00;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      host.rd(ra[i], r, ok);
      chk({ok, r}, {1'b1, rv[i]}, "reset value");
    end
    chk(noise.band_in_use_dbuv, exp_dbuv(3'h3), "reset level");
    chk(modem.rate_bps, exp_bps(2'h3), "reset rate");
    $display("test reset done");
    g = 4'hB;
    for (int i = 0; i < 16; i++) begin
      v = xs();
      w = xs();
      if (i == 0) v[3:0] = 4'hF;
      if (v[3:0] != 4'hF) g = v[3:0];
      wr_rd(8'h32, {4'h0, v[3:0]}, {4'h0, g});
      chk(modem.tx_gain, g, "tx gain");
      wr_rd(8'h33, v[15:8], {5'h00, v[10:8]});
      chk(modem.rx_gain, v[10:8], "rx gain");
      wr_rd(8'h31, v[23:16], v[23:16] & 8'h73);
      chk(modem.rate_bps, exp_bps(v[17:16]), "bit rate");
      chk(modem.zero_tone_100hz, 16'h0535, "zero tone");
      chk(modem.one_tone_100hz, v[20] ? 16'h0518 : 16'h0526, "one tone");
      chk({modem.tx_delay, modem.tone_deviation_select, modem.bit_rate}, {v[22:20], v[17:16]}, "modem fields");
      @(posedge clk);
      auto_noise_code <= v[27:25];
      wr_rd(8'h30, {4'h0, v[31:28]}, {4'h0, v[31:28]});
      c = v[31] ? v[27:25] : v[30:28];
      chk(noise.band_in_use_code, c, "threshold code");
      chk(noise.band_in_use_dbuv, exp_dbuv(c), "threshold level");
      chk({noise.auto_noise_threshold, noise.noise_threshold_code}, v[31:28], "threshold fields");
      w[6] = w[6] & ~w[5];
      wr_rd(8'h07, w[7:0], w[7:0]);
      chk(tx_ctrl.retry_count, w[3:0], "retry count");
      chk(tx_ctrl.ack_mode, w[4], "service type");
      chk({tx_ctrl.source_addr_kind, tx_ctrl.dest_addr_kind}, w[7:5], "address kinds");
    end
    $display("test fields done");
    for (int i = 0; i < 8; i++) begin
      v = xs();
      phys = {phys[55:0], v[7:0]};
      host.wr(8'h08 + 8'(i), v[7:0]);
    end
    // The last byte lands at the edge that ends the write, so look once it has settled.
    @(negedge clk);
    chk(dest_addr.physical, phys, "physical");
    chk(dest_addr.logical16, {phys[55:48], phys[63:56]}, "logical16");
    chk(dest_addr.logical8, phys[63:56], "logical8");
    $display("test address done");
    pulse(0);
    chk({rx_accept, rx_dropped}, 2'h2, "first packet");
    host.rd(8'h40, r, ok);
    chk(r, 8'h80, "flag set");
    pulse(0);
    chk({rx_accept, rx_dropped}, 2'h1, "dropped packet");
    host.wr(8'h40, 8'h00);
    @(negedge clk);
    chk(int_status_clear, 1'b1, "status clear");
    pulse(0);
    chk({rx_accept, rx_dropped}, 2'h2, "packet after clear");
    $display("test receive done");
    host.wr(8'h07, 8'h13);
    host.wr(8'h06, 8'h85);
    @(negedge clk);
    chk({tx_ctrl.send, tx_ctrl.payload_len}, 6'h25, "send set");
    pulse(1);
    chk({tx_ctrl.send, ack_pending}, 2'h1, "send cleared");
    pulse(2);
    miss = 0;
    for (k = 0; k < ACK + 5; k++) begin
      @(negedge clk);
      miss += int'(ack_missing !== 1'b0) + int'(ack_pending !== 1'b0);
    end
    chk(miss, 0, "ack received");
    pulse(1);
    k = 0;
    while (ack_missing !== 1'b1 && k < ACK + 5) begin
      @(negedge clk);
      k++;
    end
    chk({ack_missing, ack_pending}, 2'h2, "ack missing");
    chk(k >= ACK - 3 && k <= ACK + 2, 1'b1, "ack window");
    host.wr(8'h07, 8'h03);
    pulse(1);
    chk(ack_pending, 1'b0, "unacknowledged");
    $display("test transmit done");
    wrap_up();
  end
endmodule : tb_powerline_modem_config_regs
`default_nettype wire
